/* sfr_upper_pkg.sv */
// Constants for the upper-bank special-function register decode
package sfr_upper_pkg;
    localparam logic [8:0] ADDR_WINDOW_B2 = 9'h100;
    localparam logic [8:0] ADDR_TIMER0_B2 = 9'h101;
    localparam logic [8:0] ADDR_PCLOW_B2 = 9'h102;
    localparam logic [8:0] ADDR_FLAGS_B2 = 9'h103;
    localparam logic [8:0] ADDR_POINTER_B2 = 9'h104;
    localparam logic [8:0] ADDR_PORT_B_LATCH_PINS_B2 = 9'h106;
    localparam logic [8:0] ADDR_PCUPPER_B2 = 9'h10a;
    localparam logic [8:0] ADDR_INTCTL_B2 = 9'h10b;
    localparam logic [8:0] ADDR_WINDOW_B3 = 9'h180;
    localparam logic [8:0] ADDR_OPTIONS_B3 = 9'h181;
    localparam logic [8:0] ADDR_PCLOW_B3 = 9'h182;
    localparam logic [8:0] ADDR_FLAGS_B3 = 9'h183;
    localparam logic [8:0] ADDR_POINTER_B3 = 9'h184;
    localparam logic [8:0] ADDR_PORT_B_LATCH_PINS_DIR_B3 = 9'h186;
    localparam logic [8:0] ADDR_PCUPPER_B3 = 9'h18a;
    localparam logic [8:0] ADDR_INTCTL_B3 = 9'h18b;
    // Block-local status and mask for the interrupt output
    localparam logic [8:0] ADDR_EVT_STATUS = 9'h1f0;
    localparam logic [8:0] ADDR_EVT_MASK = 9'h1f1;
    // Low seven bits: offset inside a bank
    localparam logic [6:0] OFS_WINDOW = 7'h00;
    localparam logic [6:0] OFS_PCLOW = 7'h02;
    localparam logic [6:0] OFS_FLAGS = 7'h03;
    localparam logic [6:0] OFS_POINTER = 7'h04;
    localparam logic [6:0] OFS_PCUPPER = 7'h0a;
    localparam logic [6:0] OFS_INTCTL = 7'h0b;
    localparam int PC_UPPER_W = 5;
    localparam logic [7:0] RST_ZERO = 8'h00;
    localparam logic [7:0] RST_ONES = 8'hff;
    localparam logic [7:0] RST_FLAGS_POR = 8'h18;
    localparam logic [7:0] FLAGS_KEEP_MASK = 8'h07;
    localparam logic [7:0] INTCTL_KEEP_MASK = 8'h01;
    localparam int FLAG_TO_BIT = 4;
    localparam int FLAG_PD_BIT = 3;
    localparam int EVT_W = 3;
    localparam int EVT_PCLOAD = 0;
    localparam int EVT_WDT = 1;
    localparam int EVT_PINRST = 2;
endpackage

/* sfr_upper_bank.sv */
// Upper-bank special-function register decode with indirect window
//
// Design decision made here: the strobed register port.
`timescale 1ns/10ps
`default_nettype none
module sfr_upper_bank
    import sfr_upper_pkg::*;
(
    // Clock and resets
    input wire logic clk_in,
    input wire logic sys_rst_in,
    input wire logic por_rst_in,
    input wire logic pin_rst_in,
    input wire logic wdt_rst_in,
    // Register port
    input wire logic [8:0] addr_in,
    input wire logic [7:0] wdata_in,
    input wire logic wr_in,
    input wire logic rd_in,
    output logic [7:0] rdata_out,
    // Indirect target access
    output logic [7:0] ind_addr_out,
    output logic ind_wr_out,
    output logic [7:0] ind_wdata_out,
    input wire logic [7:0] ind_rdata_in,
    // Neighbouring logic
    input wire logic [7:0] timer0_in,
    input wire logic [7:0] port_b_pins_in,
    input wire logic [2:0] irq_flag_set_in,
    output logic [7:0] timer0_wdata_out,
    output logic timer0_wr_out,
    output logic [7:0] port_b_latch_out,
    output logic [7:0] port_b_direction_out,
    output logic [7:0] core_options_out,
    output logic [7:0] processor_flags_out,
    output logic [7:0] interrupt_control_out,
    output logic [12:0] pc_out,
    output logic irq_out
);
    logic [7:0] pointer_ff;
    logic [7:0] pc_low_ff;
    logic [PC_UPPER_W-1:0] pc_upper_ff;
    logic [PC_UPPER_W-1:0] pc_holding_ff;
    logic [7:0] flags_ff;
    logic [7:0] intctl_ff;
    logic [7:0] options_ff;
    logic [7:0] latch_b_ff;
    logic [7:0] dir_b_ff;
    logic [EVT_W-1:0] evt_status_ff;
    logic [EVT_W-1:0] evt_mask_ff;
    logic [7:0] rdata_ff;
    logic rd_window_ff;
    logic ind_wr_ff;
    logic [7:0] ind_wdata_ff;
    logic tmr_wr_ff;
    logic [7:0] tmr_wdata_ff;
    logic irq_ff;
    logic [2:0] pin_sync_ff;
    logic [2:0] wdt_sync_ff;
    logic pin_level_ff;
    logic wdt_level_ff;
    logic pin_rst_ev;
    logic wdt_rst_ev;
    logic other_rst;
    logic [6:0] ofs;
    logic banked;
    logic [7:0] nxt_rdata;

    assign ofs = addr_in[6:0];
    // banks 2 and 3 share core slots; lower banks belong elsewhere
    assign banked = addr_in[8];

    // Pin-level reset sources pass three stages; agreement of last two counts
    always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin
            pin_sync_ff <= 3'h0;
            wdt_sync_ff <= 3'h0;
            pin_level_ff <= 1'b0;
            wdt_level_ff <= 1'b0;
        end else begin
            pin_sync_ff <= {pin_sync_ff[1:0], pin_rst_in};
            wdt_sync_ff <= {wdt_sync_ff[1:0], wdt_rst_in};
            if (pin_sync_ff[2] == pin_sync_ff[1]) begin
                pin_level_ff <= pin_sync_ff[2];
            end
            if (wdt_sync_ff[2] == wdt_sync_ff[1]) begin
                wdt_level_ff <= wdt_sync_ff[2];
            end
        end
    end
    assign pin_rst_ev = pin_sync_ff[2] & pin_sync_ff[1] & ~pin_level_ff;
    assign wdt_rst_ev = wdt_sync_ff[2] & wdt_sync_ff[1] & ~wdt_level_ff;
    // pin and watchdog are non-power-up resets
    assign other_rst = pin_rst_ev | wdt_rst_ev;

    // Pointer, indirect target
    always_ff @(posedge clk_in) begin
        if (sys_rst_in | por_rst_in) begin
            pointer_ff <= RST_ZERO;
        end else if (!other_rst && wr_in && banked && ofs == OFS_POINTER) begin
            pointer_ff <= wdata_in;
        end
    end

    always_ff @(posedge clk_in) begin
        if (sys_rst_in | por_rst_in | other_rst) begin
            ind_wr_ff <= 1'b0;
            ind_wdata_ff <= RST_ZERO;
        end else begin
            ind_wr_ff <= wr_in && banked && ofs == OFS_WINDOW;
            ind_wdata_ff <= wdata_in;
        end
    end

    // Program counter low byte, holding latch, upper part
    always_ff @(posedge clk_in) begin
        if (sys_rst_in | por_rst_in | other_rst) begin
            pc_low_ff <= RST_ZERO;
            pc_upper_ff <= '0;
            pc_holding_ff <= '0;
        end else begin
            if (wr_in && banked && ofs == OFS_PCUPPER) begin
                pc_holding_ff <= wdata_in[PC_UPPER_W-1:0];
            end
            if (wr_in && banked && ofs == OFS_PCLOW) begin
                pc_low_ff <= wdata_in;
                pc_upper_ff <= pc_holding_ff;
            end
        end
    end

    // Processor flags
    always_ff @(posedge clk_in) begin
        if (sys_rst_in | por_rst_in) begin
            flags_ff <= RST_FLAGS_POR;
        end else if (other_rst) begin
            // bank bits cleared, arithmetic kept, TO by cause, PD kept
            flags_ff <= flags_ff & FLAGS_KEEP_MASK;
            flags_ff[FLAG_TO_BIT] <= ~wdt_rst_ev;
            flags_ff[FLAG_PD_BIT] <= flags_ff[FLAG_PD_BIT];
        end else if (wr_in && banked && ofs == OFS_FLAGS) begin
            // TO and PD are not writable by software
            flags_ff[7:5] <= wdata_in[7:5];
            flags_ff[2:0] <= wdata_in[2:0];
        end
    end

    // Interrupt control
    always_ff @(posedge clk_in) begin
        if (sys_rst_in | por_rst_in) begin
            intctl_ff <= RST_ZERO;
        end else if (other_rst) begin
            intctl_ff <= intctl_ff & INTCTL_KEEP_MASK;
        end else begin
            // flags set by hardware win over the clearing write
            if (wr_in && banked && ofs == OFS_INTCTL) begin
                intctl_ff <= {wdata_in[7:3], wdata_in[2:0] | irq_flag_set_in};
            end else begin
                intctl_ff[2:0] <= intctl_ff[2:0] | irq_flag_set_in;
            end
        end
    end

    // Bank-specific registers; timer write passes to the timer
    always_ff @(posedge clk_in) begin
        if (sys_rst_in | por_rst_in | other_rst) begin
            options_ff <= RST_ONES;
            dir_b_ff <= RST_ONES;
            tmr_wr_ff <= 1'b0;
            tmr_wdata_ff <= RST_ZERO;
        end else begin
            tmr_wr_ff <= wr_in && addr_in == ADDR_TIMER0_B2;
            tmr_wdata_ff <= wdata_in;
            if (wr_in && addr_in == ADDR_OPTIONS_B3) begin
                options_ff <= wdata_in;
            end
            if (wr_in && addr_in == ADDR_PORT_B_LATCH_PINS_DIR_B3) begin
                dir_b_ff <= wdata_in;
            end
        end
    end

    // Port latch kept over every reset but power-on and system reset
    always_ff @(posedge clk_in) begin
        if (sys_rst_in | por_rst_in) begin
            latch_b_ff <= RST_ZERO;
        end else if (!other_rst && wr_in && addr_in == ADDR_PORT_B_LATCH_PINS_B2) begin
            latch_b_ff <= wdata_in;
        end
    end

    // Event status: set wins over write-one-to-clear
    always_ff @(posedge clk_in) begin
        if (sys_rst_in | por_rst_in) begin
            evt_status_ff <= '0;
            evt_mask_ff <= '0;
            irq_ff <= 1'b0;
        end else begin
            evt_status_ff <= (evt_status_ff
                & ~((wr_in && addr_in == ADDR_EVT_STATUS) ? wdata_in[EVT_W-1:0] : '0))
                | {pin_rst_ev, wdt_rst_ev,
                   wr_in && banked && ofs == OFS_PCLOW};
            if (wr_in && addr_in == ADDR_EVT_MASK) begin
                evt_mask_ff <= wdata_in[EVT_W-1:0];
            end
            irq_ff <= |(evt_status_ff & evt_mask_ff);
        end
    end

    // unmapped and unused bits read zero
    always_comb begin
        nxt_rdata = RST_ZERO;
        if (banked && ofs == OFS_POINTER) begin
            nxt_rdata = pointer_ff;
        end else if (banked && ofs == OFS_PCLOW) begin
            nxt_rdata = pc_low_ff;
        end else if (banked && ofs == OFS_FLAGS) begin
            nxt_rdata = flags_ff;
        end else if (banked && ofs == OFS_PCUPPER) begin
            nxt_rdata = {3'h0, pc_holding_ff};
        end else if (banked && ofs == OFS_INTCTL) begin
            nxt_rdata = intctl_ff;
        end else if (addr_in == ADDR_TIMER0_B2) begin
            nxt_rdata = timer0_in;
        end else if (addr_in == ADDR_PORT_B_LATCH_PINS_B2) begin
            nxt_rdata = port_b_pins_in;
        end else if (addr_in == ADDR_OPTIONS_B3) begin
            nxt_rdata = options_ff;
        end else if (addr_in == ADDR_PORT_B_LATCH_PINS_DIR_B3) begin
            nxt_rdata = dir_b_ff;
        end else if (addr_in == ADDR_EVT_STATUS) begin
            nxt_rdata = {5'h00, evt_status_ff};
        end else if (addr_in == ADDR_EVT_MASK) begin
            nxt_rdata = {5'h00, evt_mask_ff};
        end
    end

    always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin
            rdata_ff <= RST_ZERO;
            rd_window_ff <= 1'b0;
        end else begin
            rdata_ff <= rd_in ? nxt_rdata : RST_ZERO;
            rd_window_ff <= rd_in && banked && ofs == OFS_WINDOW;
        end
    end

    // Window read data comes from the target the cycle after
    assign rdata_out = rd_window_ff ? ind_rdata_in : rdata_ff;
    assign ind_addr_out = pointer_ff;
    assign ind_wr_out = ind_wr_ff;
    assign ind_wdata_out = ind_wdata_ff;
    assign timer0_wdata_out = tmr_wdata_ff;
    assign timer0_wr_out = tmr_wr_ff;
    assign port_b_latch_out = latch_b_ff;
    assign port_b_direction_out = dir_b_ff;
    assign core_options_out = options_ff;
    assign processor_flags_out = flags_ff;
    assign interrupt_control_out = intctl_ff;
    assign pc_out = {pc_upper_ff, pc_low_ff};
    assign irq_out = irq_ff;

    // upper part follows latch after low-byte write
    a_pc_upper_load: assert property (@(posedge clk_in) disable iff (sys_rst_in)
        (wr_in && banked && ofs == OFS_PCLOW && !por_rst_in && !other_rst)
        |=> pc_upper_ff == $past(pc_holding_ff))
        else $error("pc upper not loaded from latch");
    a_holding_read: assert property (@(posedge clk_in) disable iff (sys_rst_in)
        (rd_in && ofs == OFS_PCUPPER) |=> rdata_out[7:5] == 3'h0)
        else $error("holding latch upper bits nonzero");
    // same pointer seen from bank 2 and 3
    a_bank_mirror: assert property (@(posedge clk_in) disable iff (sys_rst_in)
        (rd_in && addr_in == ADDR_POINTER_B3) |=> rdata_out == $past(pointer_ff))
        else $error("pointer not mirrored in bank 3");
    a_unimpl_zero: assert property (@(posedge clk_in) disable iff (sys_rst_in)
        (rd_in && addr_in == 9'h105) |=> rdata_out == RST_ZERO)
        else $error("unimplemented address read nonzero");
    // arithmetic flags kept on other reset
    a_flags_keep: assert property (@(posedge clk_in) disable iff (sys_rst_in || por_rst_in)
        other_rst |=> flags_ff[2:0] == $past(flags_ff[2:0]) && flags_ff[7:5] == 3'h0)
        else $error("flags wrong after other reset");
    a_wdt_cause: assert property (@(posedge clk_in) disable iff (sys_rst_in || por_rst_in)
        wdt_rst_ev |=> !flags_ff[FLAG_TO_BIT])
        else $error("timeout bit not cleared by watchdog");
    a_pointer_keep: assert property (@(posedge clk_in) disable iff (sys_rst_in || por_rst_in)
        other_rst |=> $stable(pointer_ff))
        else $error("pointer changed on other reset");
    a_intctl_flag: assert property (@(posedge clk_in) disable iff (sys_rst_in || por_rst_in)
        (irq_flag_set_in[0] && !other_rst) ##1 !other_rst |-> intctl_ff[0])
        else $error("interrupt flag lost");
    a_window_fwd: assert property (@(posedge clk_in) disable iff (sys_rst_in || por_rst_in)
        (wr_in && banked && ofs == OFS_WINDOW && !other_rst)
        |=> ind_wr_out && ind_wdata_out == $past(wdata_in))
        else $error("window write not forwarded");

    a_pointer_write: assert property (@(posedge clk_in) disable iff (sys_rst_in || por_rst_in)
        (wr_in && banked && ofs == OFS_POINTER && !other_rst) |=> pointer_ff == $past(wdata_in))
        else $error("pointer write lost");

    // latch keeps the low five bits written
    a_holding_write: assert property (@(posedge clk_in) disable iff (sys_rst_in || por_rst_in)
        (wr_in && banked && ofs == OFS_PCUPPER && !other_rst)
        |=> pc_holding_ff == $past(wdata_in[PC_UPPER_W-1:0]))
        else $error("holding latch write lost");

    // low byte takes the written value
    a_pc_low_load: assert property (@(posedge clk_in) disable iff (sys_rst_in || por_rst_in)
        (wr_in && banked && ofs == OFS_PCLOW && !other_rst) |=> pc_low_ff == $past(wdata_in))
        else $error("pc low byte not loaded");

    // upper part moves only on a low-byte load
    a_upper_hidden: assert property (@(posedge clk_in) disable iff (sys_rst_in || por_rst_in)
        (!(wr_in && banked && ofs == OFS_PCLOW) && !other_rst) |=> $stable(pc_upper_ff))
        else $error("pc upper changed without low-byte load");

    // timeout and power-down bits not writable
    a_flags_tp_ro: assert property (@(posedge clk_in) disable iff (sys_rst_in || por_rst_in)
        (wr_in && banked && ofs == OFS_FLAGS && !other_rst)
        |=> flags_ff[4:3] == $past(flags_ff[4:3]))
        else $error("timeout or power-down bit written");

    // other reset clears all but the port-change flag
    a_intctl_keep: assert property (@(posedge clk_in) disable iff (sys_rst_in || por_rst_in)
        other_rst |=> intctl_ff == {7'h00, $past(intctl_ff[0])})
        else $error("interrupt control wrong after other reset");

    // window read returns the target data
    a_window_read: assert property (@(posedge clk_in) disable iff (sys_rst_in || por_rst_in)
        (rd_in && banked && ofs == OFS_WINDOW) |=> rdata_out == ind_rdata_in)
        else $error("window read not from target");

    // pin reset leaves the timeout bit set
    a_pin_cause: assert property (@(posedge clk_in) disable iff (sys_rst_in || por_rst_in)
        (pin_rst_ev && !wdt_rst_ev) |=> flags_ff[FLAG_TO_BIT])
        else $error("timeout bit cleared by pin reset");

    // first address of the unused range reads zero
    a_unimpl_high: assert property (@(posedge clk_in) disable iff (sys_rst_in || por_rst_in)
        (rd_in && addr_in == 9'h10c) |=> rdata_out == RST_ZERO)
        else $error("unused range read nonzero");

    // read data idle at zero outside a read
    a_idle_zero: assert property (@(posedge clk_in) disable iff (sys_rst_in || por_rst_in)
        !rd_in |=> rdata_out == RST_ZERO)
        else $error("read data nonzero without read");
endmodule
`default_nettype wire

/* data_mem_model.sv */
// Data memory reached through the indirect window
`timescale 1ns/10ps
`default_nettype none
module data_mem_model (
    // Clock
    input wire logic clk_in,
    // Access from the window
    input wire logic [7:0] addr_in,
    input wire logic wr_in,
    input wire logic [7:0] wdata_in,
    output logic [7:0] rdata_out
);
    logic [7:0] mem [256];

    // Distinct fill so a wrong location shows up at once
    initial begin
        for (int i = 0; i < 256; i++) begin
            mem[i] = i[7:0] ^ 8'h5a;
        end
    end

    always_ff @(posedge clk_in) begin
        if (wr_in) begin
            mem[addr_in] <= wdata_in;
        end
    end

    assign rdata_out = mem[addr_in];
endmodule
`default_nettype wire

/* sfr_upper_bank_tb.sv */
// Self-checking bench for the upper-bank register decode
`timescale 1ns/10ps
`default_nettype none
module sfr_upper_bank_tb
    import sfr_upper_pkg::*;
;
    logic clk_in = 1'b0;
    logic sys_rst_in, pin_rst_in, wdt_rst_in, wr_in, rd_in, ind_wr_out, timer0_wr_out, irq_out;
    logic por_rst_in;
    logic [8:0] addr_in;
    logic [7:0] wdata_in, rdata_out, ind_addr_out, ind_wdata_out, ind_rdata_in;
    logic [7:0] timer0_wdata_out, port_b_latch_out, port_b_direction_out, core_options_out;
    logic [7:0] processor_flags_out, interrupt_control_out;
    logic [12:0] pc_out;
    logic [2:0] irq_flag_set_in;
    int err_count = 0;
    int samples_checked = 0;
    int cycles = 0;
    logic [8:0] unmapped [8] = '{9'h105, 9'h107, 9'h108, 9'h109, 9'h10c, 9'h11f, 9'h185, 9'h187};

    sfr_upper_bank DUT (
        .clk_in(clk_in), .sys_rst_in(sys_rst_in), .por_rst_in(por_rst_in),
        .pin_rst_in(pin_rst_in), .wdt_rst_in(wdt_rst_in),
        .addr_in(addr_in), .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in),
        .rdata_out(rdata_out), .ind_addr_out(ind_addr_out), .ind_wr_out(ind_wr_out),
        .ind_wdata_out(ind_wdata_out), .ind_rdata_in(ind_rdata_in),
        .timer0_in(8'h77), .port_b_pins_in(8'h3c), .irq_flag_set_in(irq_flag_set_in),
        .timer0_wdata_out(timer0_wdata_out), .timer0_wr_out(timer0_wr_out),
        .port_b_latch_out(port_b_latch_out), .port_b_direction_out(port_b_direction_out),
        .core_options_out(core_options_out), .processor_flags_out(processor_flags_out),
        .interrupt_control_out(interrupt_control_out), .pc_out(pc_out), .irq_out(irq_out)
    );

    data_mem_model MEM (
        .clk_in(clk_in), .addr_in(ind_addr_out), .wr_in(ind_wr_out),
        .wdata_in(ind_wdata_out), .rdata_out(ind_rdata_in)
    );

    initial begin
        forever #4 clk_in = ~clk_in;
    end

    task automatic summarize();
        if (err_count == 0 && samples_checked > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        samples_checked++;
        if (got !== exp) begin
            $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
            err_count++;
        end
    endtask

    task automatic wr(input logic [8:0] a, input logic [7:0] d);
        @(posedge clk_in);
        addr_in <= a;
        wdata_in <= d;
        wr_in <= 1'b1;
        @(posedge clk_in);
        wr_in <= 1'b0;
    endtask

    task automatic rd(input logic [8:0] a, input logic [7:0] e);
        @(posedge clk_in);
        addr_in <= a;
        rd_in <= 1'b1;
        @(posedge clk_in);
        rd_in <= 1'b0;
        #1;
        chk(rdata_out, e);
    endtask

    // Level held well past the three-flop synchroniser
    task automatic other_rst(input bit from_wdt);
        @(posedge clk_in);
        wdt_rst_in <= from_wdt;
        pin_rst_in <= !from_wdt;
        repeat (6) @(posedge clk_in);
        wdt_rst_in <= 1'b0;
        pin_rst_in <= 1'b0;
        repeat (4) @(posedge clk_in);
    endtask

    always @(posedge clk_in) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            err_count++;
            summarize();
        end
    end

    initial begin
        sys_rst_in = 1'b1;
        por_rst_in = 1'b0;
        pin_rst_in = 1'b0;
        wdt_rst_in = 1'b0;
        wr_in = 1'b0;
        rd_in = 1'b0;
        addr_in = 9'h000;
        wdata_in = 8'h00;
        irq_flag_set_in = 3'h0;
        repeat (8) @(posedge clk_in);
        sys_rst_in <= 1'b0;
        rd(ADDR_POINTER_B2, 8'h00);
        rd(ADDR_FLAGS_B3, 8'h18);
        rd(ADDR_INTCTL_B2, 8'h00);
        rd(ADDR_OPTIONS_B3, 8'hff);
        rd(ADDR_PORT_B_LATCH_PINS_DIR_B3, 8'hff);
        rd(ADDR_PCUPPER_B2, 8'h00);
        rd(ADDR_TIMER0_B2, 8'h77);
        rd(ADDR_PORT_B_LATCH_PINS_B2, 8'h3c);
        for (int i = 0; i < 8; i++) begin
            wr(unmapped[i], 8'hff);
            rd(unmapped[i], 8'h00);
        end
        rd(ADDR_EVT_MASK + 9'h002, 8'h00);
        wr(9'h18a, 8'hff);
        rd(ADDR_PCUPPER_B2, 8'h1f);
        wr(ADDR_PCUPPER_B3 - 9'h080 + 9'h080, 8'h15);
        wr(ADDR_PCLOW_B3, 8'h42);
        @(posedge clk_in);
        #1;
        chk(pc_out, 16'h1542);
        rd(ADDR_PCLOW_B2, 8'h42);
        wr(ADDR_POINTER_B3, 8'h3c);
        rd(ADDR_POINTER_B2, 8'h3c);
        chk(ind_addr_out, 8'h3c);
        wr(ADDR_WINDOW_B2, 8'ha5);
        rd(ADDR_WINDOW_B3, 8'ha5);
        wr(ADDR_POINTER_B2, 8'h10);
        rd(ADDR_WINDOW_B2, 8'h4a);
        wr(ADDR_POINTER_B2, 8'h3c);
        // Status bit0 came from the low-byte write
        rd(ADDR_EVT_STATUS, 8'h01);
        chk(irq_out, 1'b0);
        wr(ADDR_EVT_MASK, 8'h01);
        repeat (2) @(posedge clk_in);
        #1;
        chk(irq_out, 1'b1);
        wr(ADDR_EVT_STATUS, 8'h01);
        repeat (2) @(posedge clk_in);
        #1;
        chk(irq_out, 1'b0);
        rd(ADDR_EVT_STATUS, 8'h00);
        wr(ADDR_FLAGS_B2, 8'h00);
        rd(ADDR_FLAGS_B2, 8'h18);
        wr(ADDR_FLAGS_B2, 8'he5);
        rd(ADDR_FLAGS_B3, 8'hfd);
        wr(ADDR_INTCTL_B2, 8'hf8);
        rd(ADDR_INTCTL_B3 - 9'h080 + 9'h080, 8'hf8);
        @(posedge clk_in);
        irq_flag_set_in <= 3'h5;
        @(posedge clk_in);
        irq_flag_set_in <= 3'h0;
        rd(ADDR_INTCTL_B2, 8'hfd);
        chk(interrupt_control_out, 8'hfd);
        wr(ADDR_INTCTL_B2, 8'hf9);
        wr(ADDR_PORT_B_LATCH_PINS_DIR_B3, 8'h12);
        wr(ADDR_OPTIONS_B3, 8'h55);
        wr(ADDR_PORT_B_LATCH_PINS_B2, 8'h6b);
        #1;
        chk(port_b_latch_out, 8'h6b);
        other_rst(1'b0);
        rd(ADDR_FLAGS_B2, 8'h1d);
        rd(ADDR_INTCTL_B2, 8'h01);
        rd(ADDR_POINTER_B2, 8'h3c);
        rd(ADDR_PCUPPER_B2, 8'h00);
        rd(ADDR_PCLOW_B2, 8'h00);
        rd(ADDR_PORT_B_LATCH_PINS_DIR_B3, 8'hff);
        rd(ADDR_OPTIONS_B3, 8'hff);
        other_rst(1'b1);
        rd(ADDR_FLAGS_B3, 8'h0d);
        rd(ADDR_POINTER_B3, 8'h3c);
        chk(pc_out, 16'h0000);
        // Power-on in mid-run restores the power-on column
        @(posedge clk_in);
        por_rst_in <= 1'b1;
        @(posedge clk_in);
        por_rst_in <= 1'b0;
        rd(ADDR_POINTER_B2, 8'h00);
        rd(ADDR_FLAGS_B2, 8'h18);
        rd(ADDR_INTCTL_B3, 8'h00);
        summarize();
    end
endmodule
`default_nettype wire
